// ==== src/vdq_pkg.sv ====
package vdq_pkg;
  // ------------------------------------------------------------
  // Command encodings on the carrier
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    VDQ_CMD_DES = 4'h0,
    VDQ_CMD_ACT = 4'h1,
    VDQ_CMD_WR = 4'h2,
    VDQ_CMD_WRA = 4'h3,
    VDQ_CMD_RD = 4'h4,
    VDQ_CMD_RDA = 4'h5,
    VDQ_CMD_PRE = 4'h6,
    VDQ_CMD_MRS = 4'h7,
    VDQ_CMD_REF = 4'h8
  } vdq_cmd_t;

  // ------------------------------------------------------------
  // Mode register selects and training-register fields
  // ------------------------------------------------------------
  localparam logic [2:0] VDQ_MR_PDA = 3'h3;      // Register holding per-device enable
  localparam logic [2:0] VDQ_MR_TRAIN = 3'h6;    // vref_training_control
  localparam int VDQ_PDA_BIT = 4;                // Per-device enable bit position
  localparam int VDQ_EN_BIT = 7;                 // Calibration enable bit
  localparam int VDQ_RANGE_BIT = 6;              // Range select bit
  localparam int VDQ_VAL_MSB = 5;                // Value field top bit
  localparam logic [7:0] VDQ_VAL_MASK = 8'h3f;   // Value field A5:A0

  // ------------------------------------------------------------
  // Timing (ns) at 50 MHz
  // ------------------------------------------------------------
  localparam int VDQ_CLK_NS = 20;
  localparam int VDQ_ENTRY_NS = 150;             // calibration_entry_delay
  localparam int VDQ_EXIT_NS = 150;              // calibration_exit_delay
  localparam int VDQ_SHORT_NS = 80;              // Short settling time
  localparam int VDQ_LONG_NS = 250;              // Long settling time
  localparam int VDQ_ENTRY_CYC = (VDQ_ENTRY_NS + VDQ_CLK_NS - 1) / VDQ_CLK_NS;
  localparam int VDQ_EXIT_CYC = (VDQ_EXIT_NS + VDQ_CLK_NS - 1) / VDQ_CLK_NS;
  localparam int VDQ_SHORT_CYC = (VDQ_SHORT_NS + VDQ_CLK_NS - 1) / VDQ_CLK_NS;
  localparam int VDQ_LONG_CYC = (VDQ_LONG_NS + VDQ_CLK_NS - 1) / VDQ_CLK_NS;
  localparam logic [5:0] VDQ_BIG_STEP = 6'h04;   // Value jump above this needs long wait

  // ------------------------------------------------------------
  // APB map of the controller
  // ------------------------------------------------------------
  localparam logic [7:0] VDQ_A_CTRL = 8'h00;     // [0] go, [1] range, [2] pda
  localparam logic [7:0] VDQ_A_VALUE = 8'h04;    // [5:0] next value to try
  localparam logic [7:0] VDQ_A_STATUS = 8'h08;   // [0] busy [1] in cal [2] err
  localparam logic [7:0] VDQ_A_OPREF = 8'h0c;    // [6:0] range and value registers, not read from the device
  localparam logic [7:0] VDQ_A_OP = 8'h10;       // [1:0] op: 1 update 2 exit 3 access
endpackage

// ==== src/vdq_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Command bus between controller and device
interface vdq_if;
  logic cmd_valid;          // One-cycle command strobe
  logic [3:0] cmd;          // Command code
  logic [2:0] mr_sel;       // Mode register select
  logic [7:0] mr_data;      // Mode register data A7:A0
  logic dq0;                // Per-device qualifier, low executes
  modport ctrl (output cmd_valid, cmd, mr_sel, mr_data, dq0);
  modport dev (input cmd_valid, cmd, mr_sel, mr_data, dq0);
endinterface
`default_nettype wire

// ==== src/vdq_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Down counter that reports when a wait is over
module vdq_timer #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic busy
);
  logic [W-1:0] cnt; // Remaining cycles
  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= count;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end
  assign busy = (cnt != '0);
endmodule
`default_nettype wire

// ==== src/vdq_device.sv ====
`timescale 1ns/1ps
`default_nettype none
module vdq_device
  import vdq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  vdq_if.dev bus,
  output logic cal_active,
  output logic ref_valid,
  output logic [6:0] dq_input_reference,
  output logic [6:0] trial_reference,
  output logic range_low_span,
  output logic dummy_write_seen,
  output logic proto_err
);
  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    VDQ_D_IDLE = 2'b00,
    VDQ_D_CAL = 2'b01,
    VDQ_D_EXIT = 2'b10
  } vdq_dstate_t;

  vdq_dstate_t state; // Mode state
  vdq_dstate_t next_state; // Next mode state
  logic pda_mode; // Per-device programming enabled
  logic [1:0] open_banks; // Count of open rows, saturating small
  logic updated; // A value was set since entry
  logic long_step; // Last update needs long settle
  logic [5:0] last_val; // Last value written

  wire cv = bus.cmd_valid;
  wire is_mrs = cv && (bus.cmd == VDQ_CMD_MRS);
  wire pda_ok = !pda_mode || !bus.dq0; // Per-device qualifier
  wire mr6 = is_mrs && (bus.mr_sel == VDQ_MR_TRAIN) && pda_ok;
  wire mr3 = is_mrs && (bus.mr_sel == VDQ_MR_PDA) && pda_ok;
  wire en_bit = bus.mr_data[VDQ_EN_BIT];
  wire rng_bit = bus.mr_data[VDQ_RANGE_BIT];
  wire [5:0] val = bus.mr_data[VDQ_VAL_MSB:0];
  wire enter = mr6 && en_bit && (state == VDQ_D_IDLE);
  wire update = mr6 && en_bit && (state == VDQ_D_CAL);
  wire leave = mr6 && !en_bit && (state == VDQ_D_CAL);
  wire [5:0] diff = (val > last_val) ? (val - last_val) : (last_val - val);
  wire legal_cal = (bus.cmd == VDQ_CMD_DES) || (bus.cmd == VDQ_CMD_ACT) ||
                   (bus.cmd == VDQ_CMD_WR) || (bus.cmd == VDQ_CMD_WRA) ||
                   (bus.cmd == VDQ_CMD_RD) || (bus.cmd == VDQ_CMD_RDA) ||
                   (bus.cmd == VDQ_CMD_PRE) || mr6 || !pda_ok;
  wire pda_bad = pda_mode && !is_mrs && (bus.cmd != VDQ_CMD_DES);
  wire err_now = cv && (
    ((state == VDQ_D_CAL) && (!legal_cal || pda_bad)) ||
    (update && (rng_bit != trial_reference[VDQ_RANGE_BIT])) ||
    (leave && (open_banks != 2'd0)) ||
    ((state == VDQ_D_EXIT) && (bus.cmd != VDQ_CMD_DES)));
  wire settle_busy; // Settling after entry/update/exit
  wire [7:0] settle_cnt = enter ? 8'(VDQ_ENTRY_CYC) :
                          leave ? 8'(VDQ_EXIT_CYC) :
                          long_step ? 8'(VDQ_LONG_CYC) : 8'(VDQ_SHORT_CYC);
  wire [7:0] upd_cnt = (diff > VDQ_BIG_STEP) ? 8'(VDQ_LONG_CYC) : 8'(VDQ_SHORT_CYC);

  // ------------------------------------------------------------
  // Settling timer
  // ------------------------------------------------------------
  vdq_timer #(.W(8)) u_settle (
    .pclk(pclk),
    .presetn(presetn),
    .load(enter || update || leave),
    .count(update ? upd_cnt : settle_cnt),
    .busy(settle_busy)
  );

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      VDQ_D_IDLE: if (enter) next_state = VDQ_D_CAL;
      VDQ_D_CAL: if (leave) next_state = VDQ_D_EXIT;
      VDQ_D_EXIT: if (!settle_busy) next_state = VDQ_D_IDLE;
      default: next_state = VDQ_D_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // Mode state and training register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= VDQ_D_IDLE;
      pda_mode <= 1'b0;
      trial_reference <= 7'h00;
      dq_input_reference <= 7'h00;
      updated <= 1'b0;
      long_step <= 1'b0;
      last_val <= 6'h00;
      dummy_write_seen <= 1'b0;
    end else begin
      state <= next_state;
      if (mr3) pda_mode <= bus.mr_data[VDQ_PDA_BIT];
      if (enter) begin
        trial_reference[VDQ_RANGE_BIT] <= rng_bit;
        updated <= 1'b0;
      end
      if (update) begin
        trial_reference[VDQ_VAL_MSB:0] <= val;
        last_val <= val;
        long_step <= (diff > VDQ_BIG_STEP);
        updated <= 1'b1;
      end
      // Writes before the first update are dummies, accepted silently outside per-device mode
      if (cv && state == VDQ_D_CAL && !updated && bus.cmd == VDQ_CMD_WR) begin
        dummy_write_seen <= 1'b1;
      end
      if (leave) dq_input_reference <= trial_reference;
    end
  end

  // ------------------------------------------------------------
  // Status outputs, all registered
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_active <= 1'b0;
      ref_valid <= 1'b0;
      range_low_span <= 1'b0;
      proto_err <= 1'b0;
      open_banks <= 2'd0;
    end else begin
      cal_active <= (next_state != VDQ_D_IDLE);
      ref_valid <= !(enter || update || leave) && !settle_busy;
      range_low_span <= trial_reference[VDQ_RANGE_BIT];
      if (err_now) proto_err <= 1'b1;
      // Bank tracking is coarse: any ACT opens, PRE closes all
      if (cv && bus.cmd == VDQ_CMD_ACT && open_banks != 2'd3) begin
        open_banks <= open_banks + 2'd1;
      end else if (cv && bus.cmd == VDQ_CMD_PRE) begin
        open_banks <= 2'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== src/vdq_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Controller end: APB registers drive the calibration sequence
module vdq_ctrl
  import vdq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  vdq_if.ctrl bus
);
  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    VDQ_C_IDLE = 3'b000,
    VDQ_C_ENTRY = 3'b001,
    VDQ_C_CAL = 3'b010,
    VDQ_C_SETTLE = 3'b011,
    VDQ_C_EXITW = 3'b100
  } vdq_cstate_t;

  vdq_cstate_t state; // Sequencer state
  logic range; // Range chosen at entry
  logic per_device_programming; // Per-device mode; refuses access ops, dq0 never driven high
  logic [5:0] value; // Value to try
  logic [1:0] op; // Pending op
  logic err; // Software asked for an illegal op
  wire busy; // Timer running

  wire acc = psel && penable; // Access phase, zero-wait
  wire wr = acc && pwrite;
  wire w_ctrl = wr && (paddr == VDQ_A_CTRL);
  wire w_val = wr && (paddr == VDQ_A_VALUE);
  wire w_op = wr && (paddr == VDQ_A_OP);
  wire mapped = (paddr == VDQ_A_CTRL) || (paddr == VDQ_A_VALUE) ||
                (paddr == VDQ_A_STATUS) || (paddr == VDQ_A_OPREF) || (paddr == VDQ_A_OP);
  wire start = w_ctrl && pwdata[0] && (state == VDQ_C_IDLE);
  wire in_cal = (state == VDQ_C_CAL);
  wire do_upd = in_cal && (op == 2'd1);
  wire do_exit = in_cal && (op == 2'd2) && !busy;
  wire do_acc = in_cal && (op == 2'd3) && !per_device_programming;
  wire [7:0] tload = start ? 8'(VDQ_ENTRY_CYC) : do_exit ? 8'(VDQ_EXIT_CYC) : 8'(VDQ_LONG_CYC);

  vdq_timer #(.W(8)) u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .load(start || do_upd || do_exit),
    .count(tload),
    .busy(busy)
  );

  // ------------------------------------------------------------
  // APB registers
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range <= 1'b0;
      per_device_programming <= 1'b0;
      value <= 6'h00;
      err <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable; // Zero wait states, pready high in the first access cycle
      pslverr <= psel && !penable && !mapped;
      if (w_ctrl && state == VDQ_C_IDLE) begin
        range <= pwdata[1];
        per_device_programming <= pwdata[2];
      end
      if (w_val) value <= pwdata[5:0];
      if (w_op && (pwdata[1:0] == 2'd3) && per_device_programming) err <= 1'b1;
      if (psel && !penable) begin
        if (paddr == VDQ_A_STATUS) begin
          prdata <= {29'h0, err, in_cal, busy || (op != 2'd0)};
        end else if (paddr == VDQ_A_CTRL) begin
          prdata <= {29'h0, per_device_programming, range, 1'b0};
        end else if (paddr == VDQ_A_VALUE) begin
          prdata <= {26'h0, value};
        end else if (paddr == VDQ_A_OPREF) begin
          prdata <= {25'h0, range, value};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer and command driver
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= VDQ_C_IDLE;
      op <= 2'd0;
      bus.cmd_valid <= 1'b0;
      bus.cmd <= VDQ_CMD_DES;
      bus.mr_sel <= 3'h0;
      bus.mr_data <= 8'h00;
      bus.dq0 <= 1'b0;
    end else begin
      bus.cmd_valid <= 1'b0;
      bus.cmd <= VDQ_CMD_DES; // Deselect unless something to send
      if (w_op && in_cal && op == 2'd0) op <= pwdata[1:0];
      case (state)
        VDQ_C_IDLE: if (start) begin
          bus.cmd_valid <= 1'b1;
          bus.cmd <= VDQ_CMD_MRS;
          bus.mr_sel <= VDQ_MR_TRAIN;
          bus.mr_data <= {1'b1, pwdata[1], 6'h00};
          state <= VDQ_C_ENTRY;
        end
        VDQ_C_ENTRY: if (!busy) state <= VDQ_C_CAL;
        VDQ_C_CAL: begin
          if (do_upd) begin
            bus.cmd_valid <= 1'b1;
            bus.cmd <= VDQ_CMD_MRS;
            bus.mr_data <= {1'b1, range, value};
            op <= 2'd0;
            state <= VDQ_C_SETTLE;
          end else if (do_exit) begin
            bus.cmd_valid <= 1'b1;
            bus.cmd <= VDQ_CMD_MRS;
            bus.mr_data <= {1'b0, range, value};
            op <= 2'd0;
            state <= VDQ_C_EXITW;
          end else if (do_acc) begin
            bus.cmd_valid <= 1'b1;
            bus.cmd <= VDQ_CMD_WR;
            op <= 2'd0;
          end else if (op == 2'd3) begin
            op <= 2'd0;
          end
        end
        VDQ_C_SETTLE: if (!busy) state <= VDQ_C_CAL;
        VDQ_C_EXITW: if (!busy) state <= VDQ_C_IDLE;
        default: state <= VDQ_C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/vdq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the command bus between the two ends
module vdq_asserts
  import vdq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd,
  input wire logic [2:0] mr_sel,
  input wire logic [7:0] mr_data,
  input wire logic dq0
);
  // ------------------------------------------------------------
  // Shadow of the device mode
  // ------------------------------------------------------------
  logic cal;       // Calibration mode seen on the bus
  logic per_device_programming;       // Per-device mode seen on the bus
  logic range_r;   // Range taken at entry
  logic row_open;  // Coarse idle tracking, as the device does it
  wire logic is_mrs = cmd_valid && cmd == VDQ_CMD_MRS;
  wire logic train_wr = is_mrs && mr_sel == VDQ_MR_TRAIN;
  wire logic entry = train_wr && mr_data[VDQ_EN_BIT] && !cal;
  wire logic update = train_wr && mr_data[VDQ_EN_BIT] && cal;
  wire logic leave = train_wr && !mr_data[VDQ_EN_BIT] && cal;
  wire logic active_cmd = cmd_valid && cmd == VDQ_CMD_ACT;
  wire logic pre_cmd = cmd_valid && cmd == VDQ_CMD_PRE;

  // Shadow follows only what the wire shows, so a wrong strobe is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal <= 1'b0;
      per_device_programming <= 1'b0;
      range_r <= 1'b0;
      row_open <= 1'b0;
    end else begin
      if (entry) begin
        cal <= 1'b1;
        range_r <= mr_data[VDQ_RANGE_BIT];
      end
      if (leave) begin
        cal <= 1'b0;
      end
      if (is_mrs && mr_sel == VDQ_MR_PDA) begin
        per_device_programming <= mr_data[VDQ_PDA_BIT];
      end
      if (active_cmd) begin
        row_open <= 1'b1;
      end else if (pre_cmd) begin
        row_open <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_is_des: assert property (!cmd_valid |-> cmd == VDQ_CMD_DES)
    else $error("bus idle without deselect code");
  a_entry_no_value: assert property (entry |-> mr_data[5:0] == 6'h00)
    else $error("entry command carries a value");
  a_entry_gap: assert property (entry |=> !cmd_valid [*7])
    else $error("command inside entry delay");
  a_update_range: assert property (update |-> mr_data[6] == range_r)
    else $error("range changed on update");
  a_update_settle: assert property (update |=> !cmd_valid [*8])
    else $error("command inside settling time");
  a_exit_range: assert property (leave |-> mr_data[6] == range_r)
    else $error("range changed on exit");
  a_exit_quiet: assert property (leave |=> !cmd_valid [*7])
    else $error("command inside exit delay");
  a_cal_legal: assert property (cmd_valid && cal |-> cmd != VDQ_CMD_REF)
    else $error("illegal command in calibration");
  a_pda_only_mrs: assert property (cmd_valid && cal && per_device_programming |-> cmd == VDQ_CMD_MRS)
    else $error("non mode-set command in per-device mode");
  a_exit_idle: assert property (leave |-> !row_open)
    else $error("exit while a row is open");

  c_entry: cover property (entry);
  c_update: cover property (update);
  c_leave: cover property (leave);
  c_dummy: cover property (cmd_valid && cal && cmd == VDQ_CMD_WR && !dq0);
endmodule
`default_nettype wire

// ==== verification/vref_dq_calibration_mode_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Drives the controller over APB and a second device directly
module vref_dq_calibration_mode_bench
  import vdq_pkg::*;
;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cal_active, ref_valid, range_low_span, dummy_write_seen, proto_err, err2;
  logic [6:0] opref, trial, opref2;
  int errors, checks;
  vdq_if bus ();
  vdq_if bus2 ();  // Second link, driven by the bench to break rules

  vdq_ctrl u_vdq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus(bus.ctrl));
  vdq_device u_vdq_device (.pclk(pclk), .presetn(presetn), .bus(bus.dev),
    .cal_active(cal_active), .ref_valid(ref_valid), .dq_input_reference(opref),
    .trial_reference(trial), .range_low_span(range_low_span),
    .dummy_write_seen(dummy_write_seen), .proto_err(proto_err));
  vdq_device u_vdq_device_b (.pclk(pclk), .presetn(presetn), .bus(bus2.dev),
    .cal_active(), .ref_valid(), .dq_input_reference(opref2), .trial_reference(),
    .range_low_span(), .dummy_write_seen(), .proto_err(err2));
  vdq_asserts u_vdq_asserts (.pclk(pclk), .presetn(presetn), .cmd_valid(bus.cmd_valid),
    .cmd(bus.cmd), .mr_sel(bus.mr_sel), .mr_data(bus.mr_data), .dq0(bus.dq0));

  // Free-running clock, 20 ns period
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task results;
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps psel from being driven twice in one step
    @(posedge pclk);
  endtask

  // Polls the busy flag; a stuck sequence ends the run
  task wait_idle;
    int n;
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 100) begin
      apb(1'b0, VDQ_A_STATUS, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b0) begin
      errors++;
      results();
    end
  endtask

  // Full pass: entry, dummy write, one update, exit
  task cal_run(input logic r, input logic [5:0] v);
    apb(1'b1, VDQ_A_CTRL, {29'h0, 1'b0, r, 1'b1});
    wait_idle();
    chk(rd[1], 1'b1);
    chk(range_low_span, r);
    apb(1'b1, VDQ_A_OP, 32'h3);
    wait_idle();
    chk(dummy_write_seen, 1'b1);
    apb(1'b1, VDQ_A_VALUE, {26'h0, v});
    apb(1'b1, VDQ_A_OP, 32'h1);
    wait_idle();
    chk(trial, {r, v});
    chk(ref_valid, 1'b1);
    apb(1'b1, VDQ_A_OP, 32'h2);
    wait_idle();
    repeat (VDQ_EXIT_CYC + 1) @(posedge pclk);
    chk(cal_active, 1'b0);
    chk(opref, {r, v});
    apb(1'b0, VDQ_A_OPREF, 32'h0);
    chk(rd, {25'h0, r, v});
  endtask

  // Raw command on the second link, then a fixed quiet spell
  task send(input logic [3:0] c, input logic [2:0] s, input logic [7:0] d);
    bus2.cmd_valid <= 1'b1;
    bus2.cmd <= c;
    bus2.mr_sel <= s;
    bus2.mr_data <= d;
    @(posedge pclk);
    bus2.cmd_valid <= 1'b0;
    bus2.cmd <= VDQ_CMD_DES;
    // Stale data inverted so the device cannot lean on it
    bus2.mr_data <= ~d;
    repeat (16) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = 32'h0;
    rerr = 1'b0;
    bus2.cmd_valid = 1'b0;
    bus2.cmd = VDQ_CMD_DES;
    bus2.mr_sel = 3'h0;
    bus2.mr_data = 8'h00;
    bus2.dq0 = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state and an unmapped address
    apb(1'b0, VDQ_A_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(rerr, 1'b1);
    // Both ranges, value at a field boundary in the first
    cal_run(1'b0, 6'h3f);
    cal_run(1'b1, 6'h05);
    chk(proto_err, 1'b0);
    apb(1'b0, VDQ_A_STATUS, 32'h0);
    chk(rd[2], 1'b0);
    // Disable write with different A6:A0 keeps the stored setting
    send(VDQ_CMD_MRS, VDQ_MR_TRAIN, 8'hc0);
    send(VDQ_CMD_MRS, VDQ_MR_TRAIN, 8'hc9);
    send(VDQ_CMD_MRS, VDQ_MR_TRAIN, 8'h51);
    chk(opref2, 7'h49);
    chk(err2, 1'b0);
    // Refresh is outside the legal set in calibration
    send(VDQ_CMD_MRS, VDQ_MR_TRAIN, 8'h80);
    send(VDQ_CMD_REF, 3'h0, 8'h00);
    chk(err2, 1'b1);
    results();
  end

  // Watchdog on the whole run
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    results();
  end
endmodule
`default_nettype wire
